// [pbs_powerup_boot_sequencer.sv]
`timescale 1ns/1ps
// power-up and reset-exit sequencer with register file and host gate
// How it works
// - initialization runs at power-up and on every rising edge of the reset pin
// - boot rom contents are copied whole into program ram
// - parameter ram is cleared to all zeros, it has no boot rom of its own
// - every control register is cleared to zero during initialization
// - data memories are also zeroed at power-up
// - default program routes serial and converter inputs straight to outputs
// - pll start-up lasts 2^18 master clock edges from reset rising
// - boot cycle after pll start-up takes about 42 us
// - with 12.288 mhz master clock whole start-up is about 21 ms
// - clock ratio is taken from the two select pins on leaving reset
// - reset release is synchronized to the falling clock edge
// - master clock may be 64, 256, 384 or 512 times sample rate
// - control source is spi, i2c or self-boot from serial eeprom
// - select pins 00,01,10,11 mean 64x, 256x, 384x, 512x
module pbs_powerup_boot_sequencer #(
	parameter int PLL_EDGES = pbs_pkg::PLL_EDGES,
	parameter int BOOT_CYC = pbs_pkg::BOOT_CYC,
	parameter int PROG_DEPTH = pbs_pkg::PROG_DEPTH,
	parameter int PARAM_DEPTH = pbs_pkg::PARAM_DEPTH,
	parameter int DATA_DEPTH = pbs_pkg::DATA_DEPTH
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire logic dev_reset_n_in,
	input wire logic master_clock_in,
	input wire logic clock_ratio_sel_0_in,
	input wire logic clock_ratio_sel_1_in,
	input wire logic [1:0] ctrl_src_sel_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic [1:0] host_space_in,
	input wire logic [pbs_pkg::AW-1:0] host_addr_in,
	input wire logic [pbs_pkg::DW-1:0] host_wdata_in,
	output logic boot_done_out,
	output logic busy_out,
	output logic pll_locked_out,
	output logic [1:0] clock_ratio_out,
	output logic [9:0] pll_mult_out,
	output logic [1:0] ctrl_source_out,
	output logic adc_mute_n_out,
	output logic dac_mute_n_out,
	output logic data_clear_n_out,
	output logic [1:0] converter_setup_field_out,
	output logic host_rd_valid_out,
	output logic [pbs_pkg::DW-1:0] host_rd_data_out,
	output logic host_refused_out
);
	localparam int AW = pbs_pkg::AW;
	localparam int DW = pbs_pkg::DW;
	localparam int RW = pbs_pkg::RW;
	localparam int NREGS = pbs_pkg::NREGS;
	localparam int FILL_A = (PROG_DEPTH > PARAM_DEPTH) ?
		PROG_DEPTH : PARAM_DEPTH;
	localparam int FILL_DEPTH = (FILL_A > DATA_DEPTH) ? FILL_A : DATA_DEPTH;
	localparam int BW = $clog2(BOOT_CYC + 1);
	localparam int IW = $clog2(NREGS);

	if (BOOT_CYC <= FILL_DEPTH) begin : g_chk_boot
		$error("BOOT_CYC must exceed the memory fill length");
	end
	if (FILL_DEPTH > 2 ** AW) begin : g_chk_depth
		$error("memory depth exceeds host address range");
	end

	typedef enum logic [3:0] {
		S_HOLD = 4'h1,
		S_PLL = 4'h2,
		S_BOOT = 4'h4,
		S_DONE = 4'h8
	} pbs_state_e;

	typedef struct packed {
		pbs_state_e state;
		logic rst_prev;
		logic [1:0] ratio_meta;
		logic [1:0] ratio_sync;
		logic [1:0] src_meta;
		logic [1:0] src_sync;
		logic cold;
		logic [BW-1:0] boot_cnt;
		logic [NREGS-1:0][RW-1:0] regs;
		logic [1:0] clock_ratio;
		logic [9:0] pll_mult;
		logic [1:0] ctrl_source;
		logic boot_done;
		logic busy;
		logic pll_locked;
		logic rd_p1;
		logic rd_reg_p1;
		logic [RW-1:0] reg_p1;
		logic rd_valid;
		logic [DW-1:0] rd_data;
		logic refused;
	} pbs_top_s;

	pbs_top_s st;
	pbs_top_s next_st;
	logic rst_pin_meta;
	logic rst_pin_sync;
	logic pll_done;
	logic init_we;
	logic host_mem_we;
	logic host_mem_re;
	logic [DW-1:0] mem_rd_data;

	// host address falls in the control register window
	function automatic logic reg_hit(input logic [AW-1:0] a);
		return a >= pbs_pkg::REG_BASE &&
			a < pbs_pkg::REG_BASE + AW'(NREGS);
	endfunction

	// register index inside the window
	function automatic logic [IW-1:0] reg_idx(input logic [AW-1:0] a);
		logic [AW-1:0] d;
		d = a - pbs_pkg::REG_BASE;
		return d[IW-1:0];
	endfunction

	// select pin pair to clock multiplier
	function automatic logic [9:0] ratio_mult(input logic [1:0] sel);
		logic [9:0] m;
		case (sel)
			2'h0: m = pbs_pkg::MULT_64;
			2'h1: m = pbs_pkg::MULT_256;
			2'h2: m = pbs_pkg::MULT_384;
			default: m = pbs_pkg::MULT_512;
		endcase
		return m;
	endfunction

	// source pins to control source, the unused code means eeprom
	function automatic logic [1:0] src_decode(input logic [1:0] sel);
		logic [1:0] s;
		case (sel)
			2'h0: s = pbs_pkg::PBS_SRC_I2C;
			2'h1: s = pbs_pkg::PBS_SRC_SPI;
			default: s = pbs_pkg::PBS_SRC_EEPROM;
		endcase
		return s;
	endfunction

	// reset pin: first stage on the rising edge
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rst_pin_meta <= 1'b0;
		end else if (clk_en_in) begin
			rst_pin_meta <= dev_reset_n_in;
		end
	end

	// second stage releases on the falling edge
	always_ff @(negedge sys_clk_in) begin
		if (!rstn_in) begin
			rst_pin_sync <= 1'b0;
		end else if (clk_en_in) begin
			rst_pin_sync <= rst_pin_meta;
		end
	end

	// fill port runs during the first part of the boot cycle
	assign init_we = st.state == S_BOOT && st.boot_cnt < BW'(FILL_DEPTH);
	// host reaches memories only once the sequence has finished
	assign host_mem_we = host_wr_in && st.state == S_DONE &&
		host_space_in != pbs_pkg::SP_REG;
	assign host_mem_re = host_rd_in && st.state == S_DONE &&
		host_space_in != pbs_pkg::SP_REG;

	// sequencer, register file and host read pipeline
	always_comb begin
		next_st = st;
		next_st.rst_prev = rst_pin_sync;
		next_st.ratio_meta = {clock_ratio_sel_0_in, clock_ratio_sel_1_in};
		next_st.ratio_sync = st.ratio_meta;
		next_st.src_meta = ctrl_src_sel_in;
		next_st.src_sync = st.src_meta;
		next_st.refused = (host_wr_in || host_rd_in) &&
			st.state != S_DONE;
		next_st.rd_p1 = 1'b0;
		next_st.rd_valid = st.rd_p1;
		if (st.rd_p1) begin
			next_st.rd_data = st.rd_reg_p1 ? DW'(st.reg_p1) : mem_rd_data;
		end
		case (st.state)
			S_HOLD: begin
				next_st.regs = '0;
				if (rst_pin_sync && !st.rst_prev) begin
					next_st.state = S_PLL;
					next_st.clock_ratio = st.ratio_sync;
					next_st.pll_mult = ratio_mult(st.ratio_sync);
					next_st.ctrl_source = src_decode(st.src_sync);
				end
			end
			S_PLL: begin
				next_st.regs = '0;
				if (pll_done) begin
					next_st.state = S_BOOT;
					next_st.boot_cnt = '0;
				end
			end
			S_BOOT: begin
				if (st.boot_cnt == BW'(BOOT_CYC - 1)) begin
					next_st.state = S_DONE;
					next_st.cold = 1'b0;
				end else begin
					next_st.boot_cnt = st.boot_cnt + 1'b1;
				end
			end
			S_DONE: begin
				// host order and skipped loads are the host's business
				if (host_wr_in && host_space_in == pbs_pkg::SP_REG &&
					reg_hit(host_addr_in)) begin
					next_st.regs[reg_idx(host_addr_in)] =
						host_wdata_in[RW-1:0];
				end
				if (host_rd_in) begin
					next_st.rd_p1 = 1'b1;
					next_st.rd_reg_p1 = host_space_in == pbs_pkg::SP_REG;
					next_st.reg_p1 = reg_hit(host_addr_in) ?
						st.regs[reg_idx(host_addr_in)] : '0;
				end
			end
			default: begin
				next_st.state = S_HOLD;
			end
		endcase
		// reset pin low aborts everything and waits for the next rise
		if (!rst_pin_sync) begin
			next_st.state = S_HOLD;
		end
		next_st.boot_done = next_st.state == S_DONE;
		next_st.busy = next_st.state != S_DONE;
		next_st.pll_locked = next_st.state == S_BOOT ||
			next_st.state == S_DONE;
	end

	// state register, cold flag survives until the first finished boot
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			st <= '0;
			st.state <= S_HOLD;
			st.cold <= 1'b1;
			st.busy <= 1'b1;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	pbs_mclk_counter #(
		.EDGES(PLL_EDGES)
	) u_mclk_counter (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.clk_en_in(clk_en_in),
		.restart_in(st.state == S_HOLD),
		.master_clock_in(master_clock_in),
		.done_out(pll_done)
	);

	pbs_boot_mem #(
		.PROG_DEPTH(PROG_DEPTH),
		.PARAM_DEPTH(PARAM_DEPTH),
		.DATA_DEPTH(DATA_DEPTH)
	) u_boot_mem (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.clk_en_in(clk_en_in),
		.init_we_in(init_we),
		.init_data_clr_in(st.cold),
		.init_addr_in(AW'(st.boot_cnt)), // counter may be wider or narrower than AW
		.host_we_in(host_mem_we),
		.host_re_in(host_mem_re),
		.host_space_in(host_space_in),
		.host_addr_in(host_addr_in),
		.host_wdata_in(host_wdata_in),
		.rd_data_out(mem_rd_data)
	);

	// outputs straight from the state register
	assign boot_done_out = st.boot_done;
	assign busy_out = st.busy;
	assign pll_locked_out = st.pll_locked;
	assign clock_ratio_out = st.clock_ratio;
	assign pll_mult_out = st.pll_mult;
	assign ctrl_source_out = st.ctrl_source;
	assign adc_mute_n_out =
		st.regs[pbs_pkg::CORE_CTRL_IDX][pbs_pkg::ADC_MUTE_BIT];
	assign dac_mute_n_out =
		st.regs[pbs_pkg::CORE_CTRL_IDX][pbs_pkg::DAC_MUTE_BIT];
	assign data_clear_n_out =
		st.regs[pbs_pkg::CORE_CTRL_IDX][pbs_pkg::DATA_CLR_BIT];
	assign converter_setup_field_out = st.regs[pbs_pkg::DAC_SETUP_IDX]
		[pbs_pkg::CONV_SETUP_LSB +: pbs_pkg::CONV_SETUP_W];
	assign host_rd_valid_out = st.rd_valid;
	assign host_rd_data_out = st.rd_data;
	assign host_refused_out = st.refused;

	a_start_on_rise: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && st.state == S_HOLD && rst_pin_sync && !st.rst_prev)
		|=> (st.state == S_PLL && !boot_done_out && busy_out))
		else $error("sequence did not start on reset rise");

	a_ratio_latch: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && st.state == S_HOLD && rst_pin_sync && !st.rst_prev)
		|=> clock_ratio_out == $past(st.ratio_sync))
		else $error("clock ratio not taken at reset exit");

	a_ratio_map: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(st.state == S_BOOT) |-> pll_mult_out == ratio_mult(clock_ratio_out))
		else $error("multiplier does not match ratio pins");

	a_pll_first: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(st.state == S_BOOT) |-> $past(pll_done) && !boot_done_out)
		else $error("boot started before pll start-up ended");

	a_boot_length: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(boot_done_out) |-> $past(st.boot_cnt) == BW'(BOOT_CYC - 1))
		else $error("boot cycle length wrong");

	a_abort_restart: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && !rst_pin_sync) |=> (st.state == S_HOLD &&
		!boot_done_out) ##1 (st.state != S_BOOT))
		else $error("reset did not abort the sequence");

	a_regs_zero: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(st.state == S_BOOT) |-> (st.regs == '0 && !adc_mute_n_out))
		else $error("control registers not cleared during boot");

	a_host_refused: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && (host_wr_in || host_rd_in) && !boot_done_out)
		|=> host_refused_out)
		else $error("host access during start-up not refused");
endmodule

// [pbs_pkg.sv]
// shared constants and types of the power-up boot sequencer
package pbs_pkg;
	// system clock and timing
	localparam int CLK_PERIOD_PS = 8000; // 125 mhz
	localparam int BOOT_TIME_NS = 42000; // boot cycle at 48 khz
	localparam int BOOT_CYC = (BOOT_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int PLL_EDGES = 2 ** 18; // master clock edges of start-up
	// widths and memory depths
	localparam int AW = 12;
	localparam int DW = 40;
	localparam int RW = 16;
	localparam int NREGS = 16;
	localparam int PROG_DEPTH = 1024;
	localparam int PARAM_DEPTH = 1024;
	localparam int DATA_DEPTH = 2048;
	// control register window and fields
	localparam logic [AW-1:0] REG_BASE = 12'h81c; // core control at 2076
	localparam int CORE_CTRL_IDX = 0;
	localparam int DAC_SETUP_IDX = 11; // dac setup at 2087
	localparam int ADC_MUTE_BIT = 4;
	localparam int DAC_MUTE_BIT = 3;
	localparam int DATA_CLR_BIT = 2;
	localparam int CONV_SETUP_LSB = 0;
	localparam int CONV_SETUP_W = 2;
	// host access spaces
	localparam logic [1:0] SP_PROG = 2'h0;
	localparam logic [1:0] SP_PARAM = 2'h1;
	localparam logic [1:0] SP_REG = 2'h2;
	localparam logic [1:0] SP_DATA = 2'h3;
	// master clock ratio multipliers
	localparam logic [9:0] MULT_64 = 10'h040;
	localparam logic [9:0] MULT_256 = 10'h100;
	localparam logic [9:0] MULT_384 = 10'h180;
	localparam logic [9:0] MULT_512 = 10'h200;
	// control source choices
	typedef enum logic [1:0] {
		PBS_SRC_I2C = 2'h0,
		PBS_SRC_SPI = 2'h1,
		PBS_SRC_EEPROM = 2'h2
	} pbs_src_e;
	// default program word layout
	localparam int FLD_W = 4;
	localparam int OP_LSB = 36;
	localparam int SRC_LSB = 32;
	localparam int DST_LSB = 28;
	localparam logic [3:0] OP_ROUTE = 4'h1;
	localparam logic [3:0] IO_SER_IN0 = 4'h0;
	localparam logic [3:0] IO_SER_IN1 = 4'h1;
	localparam logic [3:0] IO_ADC0 = 4'h2;
	localparam logic [3:0] IO_ADC1 = 4'h3;
	localparam logic [3:0] IO_DAC0 = 4'h0;
	localparam logic [3:0] IO_DAC1 = 4'h1;
	localparam logic [3:0] IO_DAC2 = 4'h2;
	localparam logic [3:0] IO_DAC3 = 4'h3;
	localparam logic [3:0] IO_SER_OUT0 = 4'h4;
	localparam logic [3:0] IO_SER_OUT1 = 4'h5;
endpackage

// [pbs_mclk_counter.sv]
`timescale 1ns/1ps
// counts master clock rising edges for the pll start-up wait
module pbs_mclk_counter #(
	parameter int EDGES = pbs_pkg::PLL_EDGES
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire logic restart_in,
	input wire logic master_clock_in,
	output logic done_out
);
	localparam int CW = $clog2(EDGES + 1);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic [CW-1:0] cnt;
		logic done;
	} pbs_cnt_s;

	pbs_cnt_s st;
	pbs_cnt_s next_st;

	if (EDGES < 2) begin : g_chk
		$error("pbs_mclk_counter: EDGES below 2");
	end

	// two-stage sync of the master clock, then count its rising edges
	always_comb begin
		next_st = st;
		next_st.meta = master_clock_in;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
		if (restart_in) begin
			next_st.cnt = '0;
			next_st.done = 1'b0;
		end else if (st.sync && !st.prev && !st.done) begin
			next_st.cnt = st.cnt + 1'b1;
			if (st.cnt == CW'(EDGES - 1)) begin
				next_st.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	assign done_out = st.done;

	a_pll_count_exact: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(st.done) |-> $past(st.cnt) == CW'(EDGES - 1))
		else $error("pll start-up ended at wrong edge count");

	a_pll_done_holds: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(st.done && !restart_in && clk_en_in) |=> st.done)
		else $error("pll start-up flag dropped without restart");
endmodule

// [pbs_boot_mem.sv]
`timescale 1ns/1ps
// program, parameter and data memories with boot fill port
module pbs_boot_mem #(
	parameter int PROG_DEPTH = pbs_pkg::PROG_DEPTH,
	parameter int PARAM_DEPTH = pbs_pkg::PARAM_DEPTH,
	parameter int DATA_DEPTH = pbs_pkg::DATA_DEPTH
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire logic init_we_in,
	input wire logic init_data_clr_in,
	input wire logic [pbs_pkg::AW-1:0] init_addr_in,
	input wire logic host_we_in,
	input wire logic host_re_in,
	input wire logic [1:0] host_space_in,
	input wire logic [pbs_pkg::AW-1:0] host_addr_in,
	input wire logic [pbs_pkg::DW-1:0] host_wdata_in,
	output logic [pbs_pkg::DW-1:0] rd_data_out
);
	localparam int AW = pbs_pkg::AW;
	localparam int DW = pbs_pkg::DW;
	localparam int PA = $clog2(PROG_DEPTH);
	localparam int QA = $clog2(PARAM_DEPTH);
	localparam int DA = $clog2(DATA_DEPTH);

	if (PROG_DEPTH > 2 ** AW || PARAM_DEPTH > 2 ** AW ||
		DATA_DEPTH > 2 ** AW) begin : g_chk
		$error("pbs_boot_mem: depth exceeds address range");
	end

	logic [DW-1:0] prog_ram [PROG_DEPTH];
	logic [DW-1:0] param_ram [PARAM_DEPTH];
	logic [DW-1:0] data_ram [DATA_DEPTH];

	// one routing word of the default program
	function automatic logic [DW-1:0] route(input logic [3:0] s,
		input logic [3:0] d);
		logic [DW-1:0] w;
		w = '0;
		w[pbs_pkg::OP_LSB +: pbs_pkg::FLD_W] = pbs_pkg::OP_ROUTE;
		w[pbs_pkg::SRC_LSB +: pbs_pkg::FLD_W] = s;
		w[pbs_pkg::DST_LSB +: pbs_pkg::FLD_W] = d;
		return w;
	endfunction

	// boot rom: plain pass-through, all words after the six routes a no-op
	function automatic logic [DW-1:0] boot_rom(input logic [AW-1:0] a);
		logic [DW-1:0] w;
		w = '0;
		case (a)
			12'h000: w = route(pbs_pkg::IO_SER_IN0, pbs_pkg::IO_DAC0);
			12'h001: w = route(pbs_pkg::IO_SER_IN1, pbs_pkg::IO_DAC1);
			12'h002: w = route(pbs_pkg::IO_SER_IN0, pbs_pkg::IO_SER_OUT0);
			12'h003: w = route(pbs_pkg::IO_SER_IN1, pbs_pkg::IO_SER_OUT1);
			12'h004: w = route(pbs_pkg::IO_ADC0, pbs_pkg::IO_DAC2);
			12'h005: w = route(pbs_pkg::IO_ADC1, pbs_pkg::IO_DAC3);
			default: w = '0;
		endcase
		return w;
	endfunction

	// boot fill and host access never meet: the sequencer gates them
	always_ff @(posedge sys_clk_in) begin
		if (clk_en_in) begin
			if (init_we_in) begin
				if (init_addr_in < PROG_DEPTH) begin
					prog_ram[init_addr_in[PA-1:0]] <= boot_rom(init_addr_in);
				end
				if (init_addr_in < PARAM_DEPTH) begin
					param_ram[init_addr_in[QA-1:0]] <= '0;
				end
				if (init_data_clr_in && init_addr_in < DATA_DEPTH) begin
					data_ram[init_addr_in[DA-1:0]] <= '0;
				end
			end else if (host_we_in) begin
				if (host_space_in == pbs_pkg::SP_PROG &&
					host_addr_in < PROG_DEPTH) begin
					prog_ram[host_addr_in[PA-1:0]] <= host_wdata_in;
				end
				if (host_space_in == pbs_pkg::SP_PARAM &&
					host_addr_in < PARAM_DEPTH) begin
					param_ram[host_addr_in[QA-1:0]] <= host_wdata_in;
				end
				if (host_space_in == pbs_pkg::SP_DATA &&
					host_addr_in < DATA_DEPTH) begin
					data_ram[host_addr_in[DA-1:0]] <= host_wdata_in;
				end
			end
		end
	end

	// registered read, zero outside the populated range
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rd_data_out <= '0;
		end else if (clk_en_in && host_re_in) begin
			rd_data_out <= '0;
			if (host_space_in == pbs_pkg::SP_PROG &&
				host_addr_in < PROG_DEPTH) begin
				rd_data_out <= prog_ram[host_addr_in[PA-1:0]];
			end
			if (host_space_in == pbs_pkg::SP_PARAM &&
				host_addr_in < PARAM_DEPTH) begin
				rd_data_out <= param_ram[host_addr_in[QA-1:0]];
			end
			if (host_space_in == pbs_pkg::SP_DATA &&
				host_addr_in < DATA_DEPTH) begin
				rd_data_out <= data_ram[host_addr_in[DA-1:0]];
			end
		end
	end

	a_prog_copy: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && init_we_in && (init_addr_in < PROG_DEPTH)) |=>
		prog_ram[$past(init_addr_in[PA-1:0])] ==
		boot_rom($past(init_addr_in)))
		else $error("program word not copied from boot rom");

	a_param_zero: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && init_we_in && (init_addr_in < PARAM_DEPTH)) |=>
		param_ram[$past(init_addr_in[QA-1:0])] == '0)
		else $error("parameter word not zeroed during boot");

	a_data_zero: assert property (
		@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && init_we_in && init_data_clr_in &&
		(init_addr_in < DATA_DEPTH)) |=>
		data_ram[$past(init_addr_in[DA-1:0])] == '0)
		else $error("data word not zeroed at power-up");
endmodule

// [pbs_clk_source.sv]
// master clock source and clock ratio pins in front of the sequencer
`timescale 1ns/1ps
module pbs_clk_source (
	input wire logic pin_n_in,
	input wire logic [1:0] code_in,
	output logic master_clock_out,
	output logic sel_0_out,
	output logic sel_1_out
);
	// free running master clock, period 40 ns
	initial master_clock_out = 1'b0;
	always #20 master_clock_out = ~master_clock_out;
	// ratio pins follow the requested code only while reset pin is low
	initial {sel_0_out, sel_1_out} = 2'h0;
	always @(pin_n_in or code_in) begin
		if (!pin_n_in) begin
			sel_0_out = code_in[1];
			sel_1_out = code_in[0];
		end
	end
endmodule

// [powerup_boot_sequencer_bench.sv]
// self-checking bench of the power-up boot sequencer
`timescale 1ns/1ps
module powerup_boot_sequencer_bench;
	logic clk = 1'b0, rstn = 1'b0, pin = 1'b1, wr = 1'b0, rd = 1'b0, rf;
	logic en = 1'b1;
	logic [1:0] src = 2'h0, code = 2'h0, sp = 2'h0, ratio, srco, conv;
	logic [11:0] addr = 12'h000;
	logic [39:0] wd = 40'h0, rdat, got, mask;
	logic mclk, s0, s1, done, busy, lock, amn, dmn, clrn, rv, refu;
	logic [9:0] mult;
	int n_fail = 0, checked = 0, cyc = 0, k, j;
	// system clock and run ceiling
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	pbs_clk_source src_u (.pin_n_in(pin), .code_in(code),
		.master_clock_out(mclk), .sel_0_out(s0), .sel_1_out(s1));
	pbs_powerup_boot_sequencer #(.PLL_EDGES(8), .BOOT_CYC(32),
		.PROG_DEPTH(16), .PARAM_DEPTH(16), .DATA_DEPTH(16)) dut_u (
		.sys_clk_in(clk), .rstn_in(rstn), .clk_en_in(en),
		.dev_reset_n_in(pin), .master_clock_in(mclk),
		.clock_ratio_sel_0_in(s0), .clock_ratio_sel_1_in(s1),
		.ctrl_src_sel_in(src), .host_wr_in(wr), .host_rd_in(rd),
		.host_space_in(sp), .host_addr_in(addr), .host_wdata_in(wd),
		.boot_done_out(done), .busy_out(busy), .pll_locked_out(lock),
		.clock_ratio_out(ratio), .pll_mult_out(mult),
		.ctrl_source_out(srco), .adc_mute_n_out(amn),
		.dac_mute_n_out(dmn), .data_clear_n_out(clrn),
		.converter_setup_field_out(conv), .host_rd_valid_out(rv),
		.host_rd_data_out(rdat), .host_refused_out(refu));
	// compare and count
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one-cycle write strobe
	task automatic wrt(input logic [1:0] s, input logic [11:0] a,
		input logic [39:0] d);
		@(negedge clk);
		{wr, sp, addr, wd} = {1'b1, s, a, d};
		@(negedge clk);
		wr = 1'b0;
	endtask
	// one-cycle read strobe, catch valid data or a refusal
	task automatic rdt(input logic [1:0] s, input logic [11:0] a,
		output logic [39:0] d);
		@(negedge clk);
		{rd, sp, addr} = {1'b1, s, a};
		@(negedge clk);
		rd = 1'b0;
		d = {40{1'bx}};
		repeat (3) begin
			if (rv === 1'b1) d = rdat;
			if (refu === 1'b1) rf = 1'b1;
			@(negedge clk);
		end
	endtask
	// bounded wait for boot done, which must not come early
	task automatic waitdone(input int lo);
		k = 0;
		while (done !== 1'b1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		chk({39'h0, (k >= lo) && (k < 300)}, 40'h1);
		chk({38'h0, lock, busy}, 40'h2);
	endtask
	task automatic rise();
		@(negedge clk) pin = 1'b1;
		waitdone(67);
	endtask
	task automatic fall();
		@(negedge clk) pin = 1'b0;
		repeat (4) @(negedge clk);
		chk({38'h0, done, busy}, 40'h1);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		rf = 1'b0;
		rdt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE, got);
		chk({39'h0, rf}, 40'h1);
		waitdone(60);
		$display("test power-up done");
		// default program routes, rest of memories and registers zero
		mask = 40'h0;
		for (j = 0; j < 6; j++) begin
			rdt(pbs_pkg::SP_PROG, 12'(j), got);
			chk({36'h0, got[39:36]}, {36'h0, pbs_pkg::OP_ROUTE});
			mask[got[35:32] * 6 + got[31:28]] = 1'b1;
		end
		chk(mask, 40'h204891);
		for (j = 0; j < 16; j++) begin
			rdt(pbs_pkg::SP_PARAM, 12'(j), got);
			chk(got, 40'h0);
			rdt(pbs_pkg::SP_DATA, 12'(j), got);
			chk(got, 40'h0);
			rdt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE + 12'(j), got);
			chk(got, 40'h0);
		end
		$display("test memories done");
		// host final setup, then an unmapped read
		wrt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE, 40'h1c);
		wrt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE + 12'h00b, 40'h1);
		wrt(pbs_pkg::SP_PARAM, 12'h003, 40'h5);
		@(negedge clk);
		chk({35'h0, amn, dmn, clrn, conv}, 40'h1d);
		// clock enable low: pin drop and register write must not be seen
		@(negedge clk) en = 1'b0;
		pin = 1'b0;
		wrt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE, 40'h0);
		repeat (4) @(negedge clk);
		chk({38'h0, done, amn}, 40'h3);
		pin = 1'b1;
		@(negedge clk) en = 1'b1;
		repeat (4) @(negedge clk);
		chk({38'h0, done, amn}, 40'h3);
		rdt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE + 12'h010, got);
		chk(got, 40'h0);
		$display("test setup done");
		// every ratio code and control source across reset pin cycles
		for (j = 0; j < 4; j++) begin
			fall();
			code = 2'(j);
			src = 2'(j);
			rise();
			chk({38'h0, ratio}, 40'(j));
			chk({30'h0, mult}, 40'(64 * (j == 0) + 128 * (j + 1) * (j > 0)));
			chk({38'h0, srco}, 40'((j == 3) ? 2 : j));
			chk({35'h0, amn, dmn, clrn, conv}, 40'h0);
			rdt(pbs_pkg::SP_PARAM, 12'h003, got);
			chk(got, 40'h0);
		end
		$display("test ratios done");
		// abort in mid start-up, then a full restart
		fall();
		@(negedge clk) pin = 1'b1;
		wrt(pbs_pkg::SP_REG, pbs_pkg::REG_BASE, 40'h1c);
		chk({38'h0, refu, amn}, 40'h2);
		repeat (20) @(negedge clk);
		chk({39'h0, done}, 40'h0);
		fall();
		rise();
		$display("test abort done");
		tally_and_finish();
	end
endmodule
